// file: rtl/radio_calib_cfg.svh
// Purpose: Constants for the calibration and power-on configuration block
// Assumes: Crystal clock ref_clk at 200 MHz, a period of 5 ns
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef RADIO_CALIB_CFG_SVH
`define RADIO_CALIB_CFG_SVH

// Register offset and reset value
`define CFG0_OFFSET      8'h18
`define CFG0_RESET       8'h04

// Field positions
`define CAL_SCHED_HI     5
`define CAL_SCHED_LO     4
`define PO_WAIT_HI       3
`define PO_WAIT_LO       2
`define PIN_CTRL_BIT     1
`define KEEP_ON_BIT      0

// Schedule settings
`define SCHED_NEVER      2'h0
`define SCHED_ON_ENTER   2'h1
`define SCHED_ON_RETURN  2'h2
`define SCHED_EVERY_4TH  2'h3

// Expiry counts of the ripple counter for wait settings 0..3
`define EXPIRE_SEL0      9'h001
`define EXPIRE_SEL1      9'h010
`define EXPIRE_SEL2      9'h040
`define EXPIRE_SEL3      9'h100

// Ripple counter length in crystal periods and clock period
`define RIPPLE_LEN       64
`define CLK_PERIOD_NS    5

`endif

// file: rtl/radio_calib_pkg.sv
// Purpose: Types shared by the calibration and power-on block
// Assumes: Nothing beyond the constants header
// Notes:   Radio state codes are those of the main state machine
package radio_calib_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_IDLE   = 3'b001,
    ST_RX     = 3'b010,
    ST_TX     = 3'b011,
    ST_SYNTH  = 3'b100
  } radio_state_e;

  typedef struct packed {
    logic [1:0] calSchedule;
    logic [1:0] powerOnWaitSel;
    logic       pinCtrlEnable;
    logic       crystalKeepOn;
  } cfg_s;

endpackage : radio_calib_pkg

// file: rtl/power_on_timer.sv
// Purpose: Power-on wait after the crystal starts, drives chip_ready_n
// Assumes: crystalStable already synchronised to ref_clk
// Notes:   Counts crystal periods, so length follows crystal frequency
`timescale 1ns/10ps
`include "radio_calib_cfg.svh"
module power_on_timer #(
  parameter int RIPPLE_LEN = `RIPPLE_LEN
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       crystalStable,
  input  wire logic [8:0] expireTarget,
  output logic            chipReadyN
);

  logic [$clog2(RIPPLE_LEN)-1:0] rippleReg;
  logic [8:0]                    expireReg;
  logic                          doneReg;
  logic                          rippleWrap;
  logic                          reachTarget;

  // One expiry each time the ripple counter wraps
  assign rippleWrap  = (rippleReg == ($clog2(RIPPLE_LEN))'(RIPPLE_LEN - 1));
  assign reachTarget = rippleWrap && ((expireReg + 9'h001) >= expireTarget);
  assign chipReadyN  = ~doneReg;

  // Counting restarts whenever the crystal drops out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rippleReg <= '0;
      expireReg <= 9'h000;
      doneReg   <= 1'b0;
    end else if (!crystalStable) begin
      rippleReg <= '0;
      expireReg <= 9'h000;
      doneReg   <= 1'b0;
    end else if (!doneReg) begin
      rippleReg <= rippleReg + 1'b1;
      if (rippleWrap) begin
        expireReg <= expireReg + 9'h001;
      end
      if (reachTarget) begin
        doneReg <= 1'b1;
      end
    end
  end

  // Ready may not fall while the crystal is unstable
  a_ready_needs_xtal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !crystalStable |=> chipReadyN)
    else $error("chip ready low without stable crystal");

  // Ready falls only at the end of a ripple period
  a_ready_on_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(chipReadyN) |-> $past(rippleWrap))
    else $error("chip ready fell outside a counter wrap");

endmodule : power_on_timer

// file: rtl/radio_calib_poweron_config.sv
// Purpose: Calibration schedule, power-on wait and crystal/pin options
// Assumes: Radio state and automatic-return flag come from same clock
// Notes:   Register written and read at its offset via the host port
//
// Summary of operation
// - Schedule 00 never calibrates alone, only on the manual strobe.
// - Schedule 01 calibrates on IDLE to RX, TX or synth-ready.
// - Schedule 10 calibrates on each automatic RX/TX return to IDLE.
// - Schedule 11 ties calibration to returns but less often.
// - Chip ready stays high until the chosen 1/16/64/256 expiries.
// - The wait is counted in crystal periods, about 0.32 to 82 us.
// - Bit 1 enables the pin radio control option.
// - Bit 0 keeps the crystal running in SLEEP.
`timescale 1ns/10ps
`include "radio_calib_cfg.svh"
module radio_calib_poweron_config
  import radio_calib_pkg::*;
#(
  parameter int RIPPLE_LEN = `RIPPLE_LEN
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         regWrite,
  input  wire logic [7:0]   regAddr,
  input  wire logic [7:0]   regWdata,
  output logic      [7:0]   regRdata,
  input  wire radio_state_e radioState,
  input  wire logic         autoReturn,
  input  wire logic         calibrateStrobe,
  input  wire logic         crystalStablePin,
  output logic              calStart,
  output logic              chipReadyN,
  output logic              pinCtrlEnable,
  output logic              crystalRun
);

  cfg_s         cfgReg;
  cfg_s         cfgNext;
  radio_state_e prevStateReg;
  logic [1:0]   returnCntReg;
  logic [1:0]   returnCntNext;
  logic         calStartReg;
  logic         calNext;
  logic [2:0]   syncReg;
  logic         stableReg;
  logic         cfgHit;
  logic         enterActive;
  logic         autoToIdle;
  logic         fourthReturn;
  logic [8:0]   expireTarget;
  logic [7:0]   regReadWord;
  logic [15:0]  stableCntReg;

  // Expiry count for a wait setting
  function automatic logic [8:0] expire_of(input logic [1:0] sel);
    case (sel)
      2'h0:    expire_of = `EXPIRE_SEL0;
      2'h1:    expire_of = `EXPIRE_SEL1;
      2'h2:    expire_of = `EXPIRE_SEL2;
      default: expire_of = `EXPIRE_SEL3;
    endcase
  endfunction : expire_of

  // True for a state that uses the synthesizer
  function automatic logic is_active(input radio_state_e st);
    is_active = (st == ST_RX) || (st == ST_TX) || (st == ST_SYNTH);
  endfunction : is_active

  // Register decode; bits 7:6 read as zero
  assign cfgHit      = (regAddr == `CFG0_OFFSET);
  assign cfgNext     = (regWrite && cfgHit) ? cfg_s'(regWdata[5:0]) : cfgReg;
  assign regReadWord = cfgHit ? {2'b00, cfgReg} : 8'h00;

  // Transition detection against the previous state
  assign enterActive  = (prevStateReg == ST_IDLE) && is_active(radioState);
  assign autoToIdle   = autoReturn && (radioState == ST_IDLE) &&
                        ((prevStateReg == ST_RX) || (prevStateReg == ST_TX));
  assign fourthReturn = autoToIdle && (returnCntReg == 2'h3);

  // Return counter only runs in the every-fourth schedule
  assign returnCntNext =
    (autoToIdle && cfgReg.calSchedule == `SCHED_EVERY_4TH) ?
    returnCntReg + 2'h1 : returnCntReg;

  // Manual strobe always works; automatic causes follow the schedule
  assign calNext = calibrateStrobe ||
    (cfgReg.calSchedule == `SCHED_ON_ENTER  && enterActive) ||
    (cfgReg.calSchedule == `SCHED_ON_RETURN && autoToIdle)  ||
    (cfgReg.calSchedule == `SCHED_EVERY_4TH && fourthReturn);

  // Pin option straight from its bit; crystal runs outside sleep or with keep-on set
  assign pinCtrlEnable = cfgReg.pinCtrlEnable;
  assign crystalRun    = (radioState != ST_SLEEP) ||
                         cfgReg.crystalKeepOn;
  assign calStart      = calStartReg;
  assign expireTarget  = expire_of(cfgReg.powerOnWaitSel);

  // Configuration, tracking and read-back registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg       <= cfg_s'(6'(`CFG0_RESET));
      prevStateReg <= ST_IDLE;
      returnCntReg <= 2'h0;
      calStartReg  <= 1'b0;
      regRdata     <= 8'h00;
    end else begin
      cfgReg       <= cfgNext;
      prevStateReg <= radioState;
      returnCntReg <= returnCntNext;
      calStartReg  <= calNext;
      regRdata     <= regReadWord;
    end
  end

  // Crystal status is analog; a change counts when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncReg   <= 3'h0;
      stableReg <= 1'b0;
    end else begin
      syncReg <= {syncReg[1:0], crystalStablePin};
      if (syncReg[1] == syncReg[2]) begin
        stableReg <= syncReg[2];
      end
    end
  end

  // Cycles since the synchronised crystal status rose; checker use only.
  // Saturates so a long stable spell cannot wrap it under a short wait
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stableCntReg <= 16'h0000;
    end else if (!stableReg) begin
      stableCntReg <= 16'h0000;
    end else if (stableCntReg != 16'hFFFF) begin
      stableCntReg <= stableCntReg + 16'h0001;
    end
  end

  // Power-on wait counted in crystal periods
  power_on_timer #(
    .RIPPLE_LEN    (RIPPLE_LEN)
  ) u_power_on_timer (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .crystalStable (stableReg),
    .expireTarget  (expireTarget),
    .chipReadyN    (chipReadyN)
  );

  // Calibration causes per schedule; the manual strobe works in all of them
  a_manual_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    calibrateStrobe |=> calStart)
    else $error("manual strobe did not request calibration");

  // Return schedule ignores everything but automatic returns and the manual strobe
  a_return_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_ON_RETURN && !autoToIdle &&
     !calibrateStrobe) |=> !calStart)
    else $error("calibration without automatic return");

  // Counter frozen outside the every-fourth schedule
  a_count_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule != `SCHED_EVERY_4TH) |=> $stable(returnCntReg))
    else $error("return counter moved outside its schedule");

  // Crystal must run in every state but sleep
  a_awake_crystal: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (radioState != ST_SLEEP) |-> crystalRun)
    else $error("crystal stopped outside sleep");

  // Pin control only moves on a write to the register
  a_pin_ctrl_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(regWrite && cfgHit) |=> $stable(pinCtrlEnable))
    else $error("pin control changed without a write");

  // Never schedule: no request unless the host strobes
  a_never_no_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_NEVER && !calibrateStrobe)
    |=> !calStart)
    else $error("auto calibration in never schedule");

  // Enter schedule: leaving IDLE for a synthesizer state calibrates
  a_enter_calib: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_ON_ENTER && $past(radioState) == ST_IDLE
     && is_active(radioState)) |=> calStart)
    else $error("missed calibration on entering active state");

  // Return schedule: every automatic return calibrates
  a_return_calib: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_ON_RETURN && autoToIdle)
    |=> calStart)
    else $error("missed calibration on automatic return");

  // Every-fourth schedule: the other returns stay quiet
  a_fourth_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_EVERY_4TH && autoToIdle &&
     returnCntReg != 2'h3 && !calibrateStrobe) |=> !calStart)
    else $error("calibration on a return that is not fourth");

  // Fourth return calibrates and the count starts over
  a_count_wraps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfgReg.calSchedule == `SCHED_EVERY_4TH && autoToIdle &&
     returnCntReg == 2'h3) |=> (calStart && returnCntReg == 2'h0))
    else $error("every-fourth counter did not wrap with calibration");

  // Pin control bit follows the last write
  a_pin_ctrl_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && cfgHit) |=> pinCtrlEnable == $past(regWdata[1]))
    else $error("pin control does not follow its bit");

  // In sleep only the keep-on bit holds the crystal up
  a_sleep_keep_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (radioState == ST_SLEEP) |-> crystalRun == cfgReg.crystalKeepOn)
    else $error("crystal run wrong in sleep");

  // Ready may fall only once the chosen expiries have elapsed; a counter
  // keeps this valid while ripple length times expiries stays within 65535
  a_wait_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(chipReadyN) |->
    (int'(stableCntReg) >= RIPPLE_LEN * int'(expireTarget)))
    else $error("chip ready fell too early");

endmodule : radio_calib_poweron_config

// file: testbench/radio_calib_poweron_config_test.sv
// Purpose: Self-checking bench for the calibration and power-on block
// Assumes: Short ripple length of 4 so the longest wait is 1024 cycles
// Notes:   Inputs change on the falling edge, outputs sampled there too
`timescale 1ns/10ps
`include "radio_calib_cfg.svh"
module radio_calib_poweron_config_test
  import radio_calib_pkg::*;
;
  localparam int RLEN = 4;

  logic         ref_clk;
  logic         rst_n;
  logic         regWrite;
  logic [7:0]   regAddr;
  logic [7:0]   regWdata;
  logic [7:0]   regRdata;
  radio_state_e radioState;
  logic         autoReturn;
  logic         calibrateStrobe;
  logic         crystalStablePin;
  logic         calStart;
  logic         chipReadyN;
  logic         pinCtrlEnable;
  logic         crystalRun;
  int           failures;
  int           testsRun;
  int           cycles = 0;

  radio_calib_poweron_config #(.RIPPLE_LEN(RLEN)) uut (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .regWrite         (regWrite),
    .regAddr          (regAddr),
    .regWdata         (regWdata),
    .regRdata         (regRdata),
    .radioState       (radioState),
    .autoReturn       (autoReturn),
    .calibrateStrobe  (calibrateStrobe),
    .crystalStablePin (crystalStablePin),
    .calStart         (calStart),
    .chipReadyN       (chipReadyN),
    .pinCtrlEnable    (pinCtrlEnable),
    .crystalRun       (crystalRun)
  );

  // Clock toggles every half period of 5 ns
  always #2.5 ref_clk = ~ref_clk;

  task automatic conclude();
    $display("failures %0d, comparisons %0d", failures, testsRun);
    if (failures == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Hang guard, the whole run needs under 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      $display("mismatch at %0t: run did not finish", $time);
      conclude();
    end
  end

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // One-cycle write strobe, released at the next falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask : wr

  // Read data is registered, so allow two full cycles after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    regAddr = a;
    repeat (2) @(negedge ref_clk);
    check({1'b0, regRdata}, {1'b0, exp});
  endtask : rd

  // Settle in one state, step to another, count request pulses after it
  task automatic cal(input radio_state_e f, input radio_state_e t,
                     input logic ar, input logic sb, input int exp);
    int n;
    n = 0;
    @(negedge ref_clk);
    radioState = f;
    repeat (3) @(negedge ref_clk);
    radioState      = t;
    autoReturn      = ar;
    calibrateStrobe = sb;
    // The request from this edge already shows at the next falling edge
    @(negedge ref_clk);
    n += (calStart === 1'b1);
    autoReturn      = 1'b0;
    calibrateStrobe = 1'b0;
    repeat (3) begin
      @(negedge ref_clk);
      n += (calStart === 1'b1);
    end
    check(n[8:0], exp[8:0]);
  endtask : cal

  // Drop the crystal, then time the fall of the ready line
  task automatic po(input logic [1:0] sel, input int exp);
    int n;
    n = 0;
    crystalStablePin = 1'b0;
    wr(8'h18, {4'h0, sel, 2'h0});
    repeat (6) @(negedge ref_clk);
    check({8'h00, chipReadyN}, 9'h001);
    crystalStablePin = 1'b1;
    while (chipReadyN !== 1'b0 && n < 1200) begin
      @(negedge ref_clk);
      n++;
    end
    check({8'h00, (n >= exp * RLEN && n <= exp * RLEN + 5)}, 9'h001);
  endtask : po

  initial begin
    ref_clk = 1'b0; rst_n = 1'b0; regWrite = 1'b0; regAddr = 8'h00;
    regWdata = 8'h00; radioState = ST_IDLE; autoReturn = 1'b0;
    calibrateStrobe = 1'b0; crystalStablePin = 1'b0;
    failures = 0; testsRun = 0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(8'h18, `CFG0_RESET);
    rd(8'h19, 8'h00);
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'h3F);
    wr(8'h19, 8'h00);
    rd(8'h18, 8'h3F);
    check({8'h00, pinCtrlEnable}, 9'h001);
    radioState = ST_SLEEP;
    #1 check({8'h00, crystalRun}, 9'h001);
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h00);
    check({8'h00, pinCtrlEnable}, 9'h000);
    check({8'h00, crystalRun}, 9'h000);
    cal(ST_SLEEP, ST_IDLE, 1'b0, 1'b0, 0);
    cal(ST_IDLE, ST_RX, 1'b0, 1'b0, 0);
    cal(ST_RX, ST_IDLE, 1'b1, 1'b0, 0);
    cal(ST_IDLE, ST_IDLE, 1'b0, 1'b1, 1);
    wr(8'h18, 8'h10);
    cal(ST_IDLE, ST_RX, 1'b0, 1'b0, 1);
    cal(ST_IDLE, ST_TX, 1'b0, 1'b0, 1);
    cal(ST_IDLE, ST_SYNTH, 1'b0, 1'b0, 1);
    cal(ST_RX, ST_IDLE, 1'b1, 1'b0, 0);
    wr(8'h18, 8'h20);
    cal(ST_IDLE, ST_RX, 1'b0, 1'b0, 0);
    cal(ST_RX, ST_IDLE, 1'b1, 1'b0, 1);
    cal(ST_TX, ST_IDLE, 1'b1, 1'b0, 1);
    cal(ST_RX, ST_IDLE, 1'b0, 1'b0, 0);
    wr(8'h18, 8'h30);
    for (int i = 0; i < 8; i++) begin
      cal(ST_TX, ST_IDLE, 1'b1, 1'b0, (i % 4 == 3));
    end
    po(2'h0, 1);
    po(2'h1, 16);
    po(2'h2, 64);
    po(2'h3, 256);
    conclude();
  end

endmodule : radio_calib_poweron_config_test
